// ### host_cfg_device.sv
// Device end: host setup, slave address and two-wire timing registers,
// strap capture, interrupt polarity, slave address match, glitch filter
// and serial clock divider. Assumes strap and line pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none
module host_cfg_device
  import cfg_regs_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Register link
  cfg_link.device         link,
  // Strap pins
  input  wire logic       strap_irq_pol,
  input  wire logic       strap_bus_mux,
  input  wire logic       byte_order_strap,
  input  wire logic       strap_bus_width,
  input  wire logic [2:0] strap_host_class,
  // Interrupt
  input  wire logic       irq_request,
  output logic            host_irq,
  // Two-wire lines and slave match
  input  wire logic       scl_pin,
  input  wire logic       sda_pin,
  input  wire logic       master_enable,
  input  wire logic       addr_valid,
  input  wire logic [6:0] addr_seen,
  output logic            scl_filtered,
  output logic            sda_filtered,
  output logic            scl_oe,
  output logic            scl_tick,
  output logic            addr_match,
  // Configuration outputs
  output logic            irq_polarity_sel,
  output logic            bus_multiplexed_sel,
  output logic            byte_order_sel,
  output logic            bus_width_sel,
  output logic [2:0]      host_class_sel,
  output logic [6:0]      own_slave_addr,
  output logic [2:0]      glitch_filter_count,
  output logic [7:0]      serial_clock_delay
);
  localparam int unsigned NPIN = 9;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;
  logic [NPIN-1:0] sync3;
  logic [NPIN-1:0] settled;
  logic [NPIN-1:0] agree;
  logic [2:0]      strap_wait;
  logic            strap_done;
  logic            strap_load;
  logic [15:0]     next_rdata;
  logic [9:0]      scl_period;
  logic [9:0]      scl_low_len;
  logic [9:0]      scl_cnt;
  logic            wr_host;
  logic            wr_slave;
  logic            wr_timing;

  assign pin_raw = {sda_pin, scl_pin, strap_host_class, strap_bus_width,
                    byte_order_strap, strap_bus_mux, strap_irq_pol};
  assign agree   = ~(sync2 ^ sync3);

  // Only stage two and three feed the settled value
  // Line bits reset high: a low reset level would fake an edge on release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1   <= {LINE_IDLE, 7'h00};
      sync2   <= {LINE_IDLE, 7'h00};
      sync3   <= {LINE_IDLE, 7'h00};
      settled <= {LINE_IDLE, 7'h00};
    end else begin
      sync1   <= pin_raw;
      sync2   <= sync1;
      sync3   <= sync2;
      settled <= (settled & ~agree) | (sync2 & agree);
    end
  end

  // Straps are caught after release, once the synchroniser has filled
  assign strap_load = !strap_done && (strap_wait == 3'(STRAP_SETTLE_CYCLES));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_wait <= 3'h0;
      strap_done <= 1'b0;
    end else if (strap_load) begin
      strap_done <= 1'b1;
    end else if (!strap_done) begin
      strap_wait <= strap_wait + 3'h1;
    end
  end

  assign wr_host   = link.wr && (link.addr == OFS_HOST_SETUP) && strap_done;
  assign wr_slave  = link.wr && (link.addr == OFS_SLAVE_ADDR);
  assign wr_timing = link.wr && (link.addr == OFS_TIMING);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_polarity_sel    <= 1'b0;
      bus_multiplexed_sel <= 1'b0;
      byte_order_sel      <= 1'b0;
      bus_width_sel       <= 1'b0;
      host_class_sel      <= 3'h0;
    end else if (strap_load) begin
      irq_polarity_sel    <= settled[0];
      bus_multiplexed_sel <= ~settled[1];
      byte_order_sel      <= settled[2];
      bus_width_sel       <= settled[3];
      host_class_sel      <= settled[6:4];
    end else if (wr_host) begin
      irq_polarity_sel    <= link.wdata[POS_IRQ_POL];
      bus_multiplexed_sel <= link.wdata[POS_BUS_MUX];
      byte_order_sel      <= link.wdata[POS_BYTE_ORDER];
      bus_width_sel       <= link.wdata[POS_BUS_WIDTH];
      host_class_sel      <= link.wdata[POS_HOST_CLASS +: 3];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      own_slave_addr <= SLAVE_ADDR_RESET;
    end else if (wr_slave) begin
      own_slave_addr <= link.wdata[POS_SLAVE_ADDR +: 7];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      glitch_filter_count <= FILTER_COUNT_RESET;
      serial_clock_delay  <= CLOCK_DELAY_RESET;
    end else if (wr_timing) begin
      glitch_filter_count <= link.wdata[POS_FILTER_COUNT +: 3];
      serial_clock_delay  <= link.wdata[POS_CLOCK_DELAY +: 8];
    end
  end

  // Reserved bits read as zero and are never stored
  always_comb begin
    next_rdata = 16'h0000;
    case (link.addr)
      OFS_HOST_SETUP: begin
        next_rdata[POS_IRQ_POL]        = irq_polarity_sel;
        next_rdata[POS_BUS_MUX]        = bus_multiplexed_sel;
        next_rdata[POS_BYTE_ORDER]     = byte_order_sel;
        next_rdata[POS_BUS_WIDTH]      = bus_width_sel;
        next_rdata[POS_HOST_CLASS +: 3] = host_class_sel;
      end
      OFS_SLAVE_ADDR: begin
        next_rdata[POS_SLAVE_ADDR +: 7] = own_slave_addr;
      end
      OFS_TIMING: begin
        next_rdata[POS_FILTER_COUNT +: 3] = glitch_filter_count;
        next_rdata[POS_CLOCK_DELAY +: 8]  = serial_clock_delay;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // Every strobe, mapped or not, is answered one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.ack   <= 1'b0;
      link.rdata <= 16'h0000;
    end else begin
      link.ack <= link.wr || link.rd;
      if (link.rd) begin
        link.rdata <= next_rdata;
      end
    end
  end

  // Inactive level before straps load is high, matching low-active reset state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_irq <= 1'b1;
    end else begin
      host_irq <= irq_polarity_sel ? irq_request : ~irq_request;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_match <= 1'b0;
    end else begin
      addr_match <= addr_valid && (addr_seen == own_slave_addr);
    end
  end

  // A line change is accepted only after count+1 stable cycles
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      logic [2:0] cnt;
      logic       level;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt   <= 3'h0;
          level <= 1'b1;
        end else if (settled[7 + gi] != level) begin
          if (cnt == glitch_filter_count) begin
            level <= settled[7 + gi];
            cnt   <= 3'h0;
          end else begin
            cnt <= cnt + 3'h1;
          end
        end else begin
          cnt <= 3'h0;
        end
      end
    end
  endgenerate

  assign scl_filtered = g_filt[0].level;
  assign sda_filtered = g_filt[1].level;

  // Odd periods give the extra cycle to the low phase
  assign scl_period  = 10'(({2'b00, serial_clock_delay} + {7'b0, glitch_filter_count}) << 1)
                       + 10'(DIV_OFFSET);
  assign scl_low_len = (scl_period + 10'h001) >> 1;

  always_ff @(posedge aclk) begin
    if (!aresetn || !master_enable) begin
      scl_cnt  <= 10'h000;
      scl_oe   <= 1'b0;
      scl_tick <= 1'b0;
    end else begin
      if (scl_cnt >= scl_period - 10'h001) begin
        scl_cnt <= 10'h000;
      end else begin
        scl_cnt <= scl_cnt + 10'h001;
      end
      scl_tick <= (scl_cnt == 10'h000);
      scl_oe   <= (scl_cnt < scl_low_len);
    end
  end
endmodule : host_cfg_device
`default_nettype wire

// ### cfg_regs_pkg.sv
// Constants, field layout and state types for the host/two-wire config bank.
// Assumes one 25 MHz clock shared by the device end and the controller end.
package cfg_regs_pkg;
  localparam int unsigned CLK_HZ              = 25000000;
  localparam int unsigned ADDR_W              = 8;
  // Register offsets on the device link
  localparam logic [3:0]  OFS_HOST_SETUP      = 4'h5;
  localparam logic [3:0]  OFS_SLAVE_ADDR      = 4'h6;
  localparam logic [3:0]  OFS_TIMING          = 4'h7;
  // Field positions
  localparam int unsigned POS_IRQ_POL         = 14;
  localparam int unsigned POS_BUS_MUX         = 13;
  localparam int unsigned POS_BYTE_ORDER      = 12;
  localparam int unsigned POS_BUS_WIDTH       = 11;
  localparam int unsigned POS_HOST_CLASS      = 8;
  localparam int unsigned POS_FILTER_COUNT    = 8;
  localparam int unsigned POS_SLAVE_ADDR      = 0;
  localparam int unsigned POS_CLOCK_DELAY     = 0;
  // Writable bits; all others read zero
  localparam logic [15:0] HOST_SETUP_WMASK    = 16'h7F00;
  localparam logic [15:0] SLAVE_ADDR_WMASK    = 16'h007F;
  localparam logic [15:0] TIMING_WMASK        = 16'h07FF;
  // Values after reset
  localparam logic [6:0]  SLAVE_ADDR_RESET    = 7'h30;
  localparam logic [2:0]  FILTER_COUNT_RESET  = 3'h0;
  localparam logic [7:0]  CLOCK_DELAY_RESET   = 8'h00;
  // Both two-wire lines rest high, so their synchronisers start there
  localparam logic [1:0]  LINE_IDLE           = 2'b11;
  localparam int unsigned STRAP_SETTLE_CYCLES = 4;
  // Limits
  localparam logic [6:0]  SLAVE_ADDR_MIN      = 7'h30;
  localparam logic [6:0]  SLAVE_ADDR_MAX      = 7'h37;
  localparam logic [2:0]  NOISY_COUNT         = 3'h3;
  localparam int unsigned DIV_OFFSET          = 15;
  localparam int unsigned FAST_MAX_HZ         = 400000;
  localparam int unsigned MIN_DIV             = (CLK_HZ + FAST_MAX_HZ - 1) / FAST_MAX_HZ;
  // Controller bus map
  localparam logic [7:0]  ADDR_STATUS         = 8'h00;
  localparam logic [7:0]  ADDR_HOST_SETUP     = {2'b00, OFS_HOST_SETUP, 2'b00};
  localparam logic [7:0]  ADDR_SLAVE_ADDR     = {2'b00, OFS_SLAVE_ADDR, 2'b00};
  localparam logic [7:0]  ADDR_TIMING         = {2'b00, OFS_TIMING, 2'b00};
  localparam logic [1:0]  RESP_OKAY           = 2'b00;
  localparam logic [1:0]  RESP_SLVERR         = 2'b10;

  typedef enum logic [1:0] {LINK_IDLE, LINK_WRITE, LINK_READ} link_state_e;
endpackage : cfg_regs_pkg

// ### cfg_link.sv
// Register link between the configuration bank and its controller.
// Single-cycle wr/rd strobes; ack one cycle later with read data.
`timescale 1ns/100ps
`default_nettype none
interface cfg_link;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        ack;
  modport device (input addr, input wdata, input wr, input rd, output rdata, output ack);
  modport host   (output addr, output wdata, output wr, output rd, input rdata, input ack);
endinterface : cfg_link
`default_nettype wire

// ### host_cfg_controller.sv
// Controller end: AXI4-Lite slave that forwards register orders over the
// link, screens values software must not write, and reports status.
// Assumes the device end answers every strobe with ack.
`timescale 1ns/100ps
`default_nettype none
module host_cfg_controller
  import cfg_regs_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  // AXI4-Lite read
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  // Register link
  cfg_link.host                  link,
  // Status
  output logic                   busy
);
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] rd_addr;
  logic [15:0]       wr_data;
  logic              wr_full;
  logic              aw_held;
  logic              w_held;
  logic              ar_held;
  logic              refused;
  logic              noisy;
  logic              wr_legal;
  logic [15:0]       wr_masked;
  logic [9:0]        req_div;
  logic              rd_dev;
  link_state_e       state;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      awready <= 1'b1;
      wr_addr <= '0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      awready <= 1'b0;
      wr_addr <= awaddr;
    end else if (bvalid && bready) begin
      aw_held <= 1'b0;
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held  <= 1'b0;
      wready  <= 1'b1;
      wr_data <= 16'h0000;
      wr_full <= 1'b0;
    end else if (wvalid && wready) begin
      w_held  <= 1'b1;
      wready  <= 1'b0;
      wr_data <= wdata[15:0];
      wr_full <= &wstrb[1:0];
    end else if (bvalid && bready) begin
      w_held <= 1'b0;
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_held <= 1'b0;
      arready <= 1'b1;
      rd_addr <= '0;
    end else if (arvalid && arready) begin
      ar_held <= 1'b1;
      arready <= 1'b0;
      rd_addr <= araddr;
    end else if (rvalid && rready) begin
      ar_held <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Partial 16-bit writes are refused: there is no copy to merge with
  always_comb begin
    wr_legal  = 1'b0;
    wr_masked = 16'h0000;
    req_div   = 10'(({2'b00, wr_data[7:0]} + {7'b0, wr_data[10:8]}) << 1) + 10'(DIV_OFFSET);
    case (wr_addr)
      ADDR_HOST_SETUP: begin
        wr_masked = wr_data & HOST_SETUP_WMASK;
        wr_legal  = wr_full;
      end
      ADDR_SLAVE_ADDR: begin
        wr_masked = wr_data & SLAVE_ADDR_WMASK;
        wr_legal  = wr_full && (wr_data[6:0] >= SLAVE_ADDR_MIN)
                    && (wr_data[6:0] <= SLAVE_ADDR_MAX);
      end
      ADDR_TIMING: begin
        wr_masked = wr_data & TIMING_WMASK;
        wr_legal  = wr_full && (req_div >= 10'(MIN_DIV));
      end
      default: begin
        wr_legal = 1'b0;
      end
    endcase
  end

  assign rd_dev = (rd_addr == ADDR_HOST_SETUP) || (rd_addr == ADDR_SLAVE_ADDR)
                  || (rd_addr == ADDR_TIMING);

  // Reads go first when both are waiting; one link order at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= LINK_IDLE;
      busy       <= 1'b0;
      link.wr    <= 1'b0;
      link.rd    <= 1'b0;
      link.addr  <= 4'h0;
      link.wdata <= 16'h0000;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
      rvalid     <= 1'b0;
      rdata      <= 32'h00000000;
      rresp      <= RESP_OKAY;
      refused    <= 1'b0;
      noisy      <= 1'b0;
    end else begin
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
      unique case (state)
        LINK_IDLE: begin
          if (ar_held && !rvalid) begin
            if (rd_addr == ADDR_STATUS) begin
              rdata  <= {29'h0, busy, noisy, refused};
              rresp  <= RESP_OKAY;
              rvalid <= 1'b1;
            end else if (rd_dev) begin
              link.rd   <= 1'b1;
              link.addr <= rd_addr[5:2];
              busy      <= 1'b1;
              state     <= LINK_READ;
            end else begin
              rdata  <= 32'h00000000;
              rresp  <= RESP_SLVERR;
              rvalid <= 1'b1;
            end
          end else if (aw_held && w_held && !bvalid) begin
            if (wr_legal) begin
              link.wr    <= 1'b1;
              link.addr  <= wr_addr[5:2];
              link.wdata <= wr_masked;
              busy       <= 1'b1;
              refused    <= 1'b0;
              state      <= LINK_WRITE;
              if (wr_addr == ADDR_TIMING) begin
                noisy <= (wr_data[10:8] >= NOISY_COUNT);
              end
            end else begin
              bresp   <= RESP_SLVERR;
              bvalid  <= 1'b1;
              refused <= 1'b1;
            end
          end
        end
        LINK_WRITE: begin
          if (link.ack) begin
            bresp  <= RESP_OKAY;
            bvalid <= 1'b1;
            busy   <= 1'b0;
            state  <= LINK_IDLE;
          end
        end
        LINK_READ: begin
          if (link.ack) begin
            rdata  <= {16'h0000, link.rdata};
            rresp  <= RESP_OKAY;
            rvalid <= 1'b1;
            busy   <= 1'b0;
            state  <= LINK_IDLE;
          end
        end
      endcase
    end
  end
endmodule : host_cfg_controller
`default_nettype wire

// ### cfg_link_chk.sv
// Checker for the register link between controller end and device end.
// Assumes one clock and a synchronous active-low reset on both ends.
`timescale 1ns/100ps
`default_nettype none
module cfg_link_chk
  import cfg_regs_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Link signals
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        ack
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_wr_ack; wr |=> ack; endproperty
  property p_ack_cause; ack |-> $past(wr) || $past(rd); endproperty
  property p_one_open; (wr || rd) |=> !(wr || rd); endproperty
  property p_host_mask;
    wr && addr == OFS_HOST_SETUP |-> (wdata & ~HOST_SETUP_WMASK) == 16'h0000;
  endproperty
  property p_own_slave_addr_wr;
    wr && addr == OFS_SLAVE_ADDR |-> wdata[15:7] == 9'h000 &&
      wdata[6:0] >= SLAVE_ADDR_MIN && wdata[6:0] <= SLAVE_ADDR_MAX;
  endproperty
  // Divisor below the fast-mode limit would overclock attached parts
  property p_tim_wr;
    wr && addr == OFS_TIMING |-> wdata[15:11] == 5'h00 &&
      2 * (int'(wdata[7:0]) + int'(wdata[10:8])) + 15 >= MIN_DIV;
  endproperty
  property p_rd_host;
    rd && addr == OFS_HOST_SETUP |=> ack && (rdata & ~HOST_SETUP_WMASK) == 16'h0000;
  endproperty
  property p_rd_own_slave_addr;
    rd && addr == OFS_SLAVE_ADDR |=> ack ##0 rdata[15:7] == 9'h000 &&
      rdata[6:0] >= SLAVE_ADDR_MIN && rdata[6:0] <= SLAVE_ADDR_MAX;
  endproperty
  property p_rd_tim; rd && addr == OFS_TIMING |=> ack && rdata[15:11] == 5'h00; endproperty

  a_wr_ack: assert property (p_wr_ack) else $error("link write not acked");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");
  a_one_open: assert property (p_one_open) else $error("strobes too close");
  a_host_mask: assert property (p_host_mask) else $error("host setup reserved set");
  a_own_slave_addr_wr: assert property (p_own_slave_addr_wr) else $error("bad slave address write");
  a_tim_wr: assert property (p_tim_wr) else $error("bad timing write");
  a_rd_host: assert property (p_rd_host) else $error("host setup reserved read");
  a_rd_own_slave_addr: assert property (p_rd_own_slave_addr) else $error("bad slave address read");
  a_rd_tim: assert property (p_rd_tim) else $error("timing reserved read");

  c_host_wr: cover property (wr && addr == OFS_HOST_SETUP);
  c_own_slave_addr_rd: cover property (rd && addr == OFS_SLAVE_ADDR);
  c_tim_wr: cover property (wr && addr == OFS_TIMING);
endmodule : cfg_link_chk
`default_nettype wire

// ### host_and_i2c_config_regs_tb.sv
// Testbench: controller and device ends joined by the link, driven over AXI4-Lite.
// Assumes a 25 MHz clock and straps steady from time zero.
`timescale 1ns/100ps
`default_nettype none
module host_and_i2c_config_regs_tb
  import cfg_regs_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, busy;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic strap_irq_pol, strap_bus_mux, byte_order_strap, strap_bus_width;
  logic [2:0] strap_host_class, host_class_sel, glitch_filter_count;
  logic irq_request, host_irq, scl_pin, master_enable, addr_valid, addr_match;
  logic scl_filtered, scl_tick, irq_polarity_sel, bus_multiplexed_sel, byte_order_sel;
  logic bus_width_sel, sda_pin, sda_filtered, scl_oe;
  logic [6:0] addr_seen, own_slave_addr;
  logic [7:0] serial_clock_delay;
  int fail_count, num_checks;

  cfg_link link();
  host_cfg_device i_host_cfg_device(.aclk, .aresetn, .link(link), .strap_irq_pol,
    .strap_bus_mux, .byte_order_strap, .strap_bus_width, .strap_host_class, .irq_request,
    .host_irq, .scl_pin, .sda_pin, .master_enable, .addr_valid, .addr_seen,
    .scl_filtered, .sda_filtered, .scl_oe, .scl_tick, .addr_match, .irq_polarity_sel,
    .bus_multiplexed_sel, .byte_order_sel, .bus_width_sel, .host_class_sel,
    .own_slave_addr, .glitch_filter_count, .serial_clock_delay);
  host_cfg_controller i_host_cfg_controller(.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .awprot(3'b000), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .arprot(3'b000), .rvalid, .rready, .rdata, .rresp, .link(link),
    .busy);
  cfg_link_chk i_cfg_link_chk(.aclk(aclk), .aresetn(aresetn), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .ack(link.ack));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic close_out;
    $display("Checks %0d, errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Each bus wait is bounded so a dead slave ends the run instead of hanging it
  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 300) begin
      chk("bus answer", 32'h1, 32'h0);
      close_out();
    end
  endtask : step

  task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    int n;
    bit aw_go;
    bit w_go;
    bit seen_busy;
    n = 0;
    aw_go = 1'b1;
    w_go = 1'b1;
    seen_busy = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'hA5A5, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Each channel is released at the edge where its own ready is seen high
    while (aw_go || w_go) begin
      step(n);
      if (aw_go && awready) begin
        aw_go = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_go && wready) begin
        w_go = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do begin
      step(n);
      if (busy === 1'b1) seen_busy = 1'b1;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    chk("busy", {31'h0, er == RESP_OKAY}, {31'h0, seen_busy});
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [15:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do step(n); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do step(n); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", {16'h0000, exp}, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : axi_rd

  function automatic logic [31:0] host_outs();
    return {25'h0, irq_polarity_sel, bus_multiplexed_sel, byte_order_sel, bus_width_sel,
            host_class_sel};
  endfunction : host_outs

  task automatic t_reset_values;
    axi_rd(ADDR_HOST_SETUP, 16'h4D00, RESP_OKAY);
    chk("host outputs", 32'h4D, host_outs());
    axi_rd(ADDR_SLAVE_ADDR, 16'h0030, RESP_OKAY);
    axi_rd(ADDR_TIMING, 16'h0000, RESP_OKAY);
    axi_rd(8'h20, 16'h0000, RESP_SLVERR);
  endtask : t_reset_values

  task automatic t_host_setup;
    axi_wr(ADDR_HOST_SETUP, 16'hFFFF, RESP_OKAY);
    axi_rd(ADDR_HOST_SETUP, 16'h7F00, RESP_OKAY);
    irq_request <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("irq high active", 32'h1, {31'h0, host_irq});
    axi_wr(ADDR_HOST_SETUP, 16'h2A00, RESP_OKAY);
    chk("host outputs", 32'h2A, host_outs());
    repeat (2) @(posedge aclk);
    chk("irq low active", 32'h0, {31'h0, host_irq});
    irq_request <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("irq low idle", 32'h1, {31'h0, host_irq});
  endtask : t_host_setup

  task automatic t_slave_addr;
    for (int v = 'h30; v <= 'h37; v++) begin
      axi_wr(ADDR_SLAVE_ADDR, 16'(v), RESP_OKAY);
      axi_rd(ADDR_SLAVE_ADDR, 16'(v), RESP_OKAY);
    end
    axi_wr(ADDR_SLAVE_ADDR, 16'h0038, RESP_SLVERR);
    axi_wr(ADDR_SLAVE_ADDR, 16'h002F, RESP_SLVERR);
    axi_rd(ADDR_SLAVE_ADDR, 16'h0037, RESP_OKAY);
    chk("own address", 32'h37, {25'h0, own_slave_addr});
    axi_rd(ADDR_STATUS, 16'h0001, RESP_OKAY);
    addr_seen <= 7'h37;
    addr_valid <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("addr match", 32'h1, {31'h0, addr_match});
    addr_seen <= 7'h36;
    repeat (2) @(posedge aclk);
    chk("addr mismatch", 32'h0, {31'h0, addr_match});
    addr_valid <= 1'b0;
  endtask : t_slave_addr

  task automatic t_timing;
    int n;
    int hi;
    axi_wr(ADDR_TIMING, 16'h0000, RESP_SLVERR);
    axi_wr(ADDR_TIMING, 16'h0235, RESP_OKAY);
    axi_rd(ADDR_STATUS, 16'h0000, RESP_OKAY);
    axi_wr(ADDR_TIMING, 16'hF318, RESP_OKAY);
    axi_rd(ADDR_TIMING, 16'h0318, RESP_OKAY);
    chk("timing outputs", 32'h0318, {21'h0, glitch_filter_count, serial_clock_delay});
    axi_rd(ADDR_STATUS, 16'h0002, RESP_OKAY);
    master_enable <= 1'b1;
    n = 0;
    do step(n); while (scl_tick !== 1'b1);
    n = 0;
    hi = 0;
    do begin
      step(n);
      if (scl_oe === 1'b1) hi++;
    end while (scl_tick !== 1'b1);
    chk("serial clock period", 32'd69, n);
    chk("serial clock low phase", 32'd35, hi);
    master_enable <= 1'b0;
    // Three low cycles settle but stay short of count 3 plus one
    scl_pin <= 1'b0;
    repeat (3) @(posedge aclk);
    scl_pin <= 1'b1;
    repeat (12) begin
      @(posedge aclk);
      if (scl_filtered !== 1'b1) chk("glitch passed", 32'h1, {31'h0, scl_filtered});
    end
    scl_pin <= 1'b0;
    sda_pin <= 1'b0;
    n = 0;
    do step(n); while ((scl_filtered !== 1'b0 || sda_filtered !== 1'b0) && n < 20);
    chk("filtered low", 32'h0, {30'h0, scl_filtered, sda_filtered});
    scl_pin <= 1'b1;
    sda_pin <= 1'b1;
  endtask : t_timing

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    {strap_irq_pol, strap_bus_mux, byte_order_strap, strap_bus_width} = 4'b1101;
    strap_host_class = 3'b101;
    {irq_request, master_enable, addr_valid} = 3'b000;
    scl_pin = 1'b1;
    sda_pin = 1'b1;
    addr_seen = 7'h00;
    fail_count = 0;
    num_checks = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    t_reset_values();
    t_host_setup();
    t_slave_addr();
    t_timing();
    close_out();
  end
endmodule : host_and_i2c_config_regs_tb
`default_nettype wire
